/* File: cfg_slave_pkg.sv */
/*
 Constants, register map and settings carrier for the two-wire
 configuration slave. Assumes a two-wire controller on the far side
 and strap pins that are stable while reset is held.
*/
// How it works
// - Answer address 11x00yy; x,yy from straps
// - Byte two high nibble: channel enables
// - Bytes three, four: four-bit boost codes
// - Byte five: swing codes, low bit one at reset
// - Byte six: de-emphasis codes, reset from straps
// - Only block transfers from byte zero
// - Discard first write data byte as offset
package cfg_slave_pkg;

   localparam int         NUM_CH        = 4;
   localparam int         PTR_W         = 4;
   localparam int         BITCNT_W      = 4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;

   localparam logic [1:0] ADDR_FIXED_HI = 2'h3;
   localparam logic [1:0] ADDR_FIXED_MID = 2'h0;

   localparam logic [3:0] IDX_UNUSED    = 4'h1;
   localparam logic [3:0] IDX_ENABLES   = 4'h2;
   localparam logic [3:0] IDX_BOOST_LO  = 4'h3;
   localparam logic [3:0] IDX_BOOST_HI  = 4'h4;
   localparam logic [3:0] IDX_SWING     = 4'h5;
   localparam logic [3:0] IDX_DEEMPH    = 4'h6;

   localparam int         EN_LSB        = 4;
   localparam logic [3:0] EN_LOW_RESET  = 4'h0;
   localparam logic       SWING_LO_RESET = 1'b1;
   localparam logic [7:0] READ_ZERO     = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ADDR  = 2'b01,
      ST_WDATA = 2'b11,
      ST_RDATA = 2'b10
   } link_state_e;

   typedef struct packed {
      logic [NUM_CH-1:0]   enable;
      logic [4*NUM_CH-1:0] boost;
      logic [2*NUM_CH-1:0] swing;
      logic [2*NUM_CH-1:0] deemph;
   } settings_s;

   typedef struct packed {
      logic       power_enable_strap;
      logic [3:0] eq_boost_code;
      logic       output_swing_code;
      logic [1:0] deemphasis_code;
      logic       addr_strap_bit4;
      logic       addr_strap_bit1;
      logic       addr_strap_bit0;
   } straps_s;

endpackage : cfg_slave_pkg

/* File: cfg_slave.sv */
/*
 Two-wire target and configuration register bank for a four-channel
 signal conditioner. Assumes an external controller drives the bus
 clock, an open-drain data wire with pull-up, and stable straps.
*/
`timescale 1ns/1ps
module cfg_slave
   import cfg_slave_pkg::*;
(
   input  wire logic      i_sys_clk,
   input  wire logic      i_rst,
   input  wire logic      i_scl,
   input  wire logic      i_sda_in,
   output logic           o_sda_out,
   output logic           o_sda_oe,
   input  wire straps_s   i_straps,
   output settings_s      o_settings
);

   // Strap capture, system domain
   straps_s   strap_meta_r;
   straps_s   strap_sync_r;
   settings_s cfg_r;
   logic      addr4_r;
   logic      addr1_r;
   logic      addr0_r;

   always_ff @(posedge i_sys_clk) begin
      strap_meta_r <= i_straps;
      strap_sync_r <= strap_meta_r;
   end

   // Address straps caught at reset, static after
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         addr4_r <= strap_sync_r.addr_strap_bit4;
         addr1_r <= strap_sync_r.addr_strap_bit1;
         addr0_r <= strap_sync_r.addr_strap_bit0;
      end
   end

   // Link domain
   logic              rst_link_meta_r;
   logic              rst_link_r;
   logic              start_tog_r;
   logic              start_seen_r;
   logic              start_new;
   link_state_e       state_r;
   logic [BITCNT_W-1:0] bit_cnt_r;
   logic [6:0]        shift_r;
   logic [7:0]        rx_byte;
   logic [PTR_W-1:0]  ptr_r;
   logic              first_w_r;
   logic              ack_pend_r;
   logic [7:0]        tx_r;
   logic [7:0]        wr_byte_r;
   logic [PTR_W-1:0]  wr_idx_r;
   logic              wr_tog_r;
   logic [6:0]        my_addr;
   logic              byte_end;
   logic              ack_edge;
   logic              addr_hit;
   logic              wr_store;
   logic              rd_load;

   always_ff @(posedge i_scl) begin
      rst_link_meta_r <= i_rst;
      rst_link_r      <= rst_link_meta_r;
   end

   // START is SDA falling while SCL high. Only reset is async here,
   // since SDA edges give no clock during reset.
   always_ff @(negedge i_sda_in or posedge i_rst) begin
      if (i_rst) begin
         start_tog_r <= 1'b0;
      end else if (i_scl) begin
         start_tog_r <= ~start_tog_r;
      end
   end

   // Toggle is settled long before the next SCL rise by bus timing
   assign start_new = start_tog_r ^ start_seen_r;
   assign rx_byte   = {shift_r, i_sda_in};
   assign my_addr   = {ADDR_FIXED_HI, addr4_r, ADDR_FIXED_MID,
                       addr1_r, addr0_r};

   // Read data: settings change only at reset or by writes of this same bus
   function automatic logic [7:0] read_byte(input logic [PTR_W-1:0] idx,
                                            input settings_s s);
      logic [7:0] v;
      v = READ_ZERO;
      case (idx)
         IDX_UNUSED:   v = READ_ZERO;
         IDX_ENABLES:  v = {s.enable, EN_LOW_RESET};
         IDX_BOOST_LO: v = s.boost[7:0];
         IDX_BOOST_HI: v = s.boost[15:8];
         IDX_SWING:    v = s.swing;
         IDX_DEEMPH:   v = s.deemph;
         default:      v = READ_ZERO;
      endcase
      return v;
   endfunction : read_byte

   // Decode shared by the link processes
   assign byte_end = (state_r != ST_IDLE) && (bit_cnt_r == LAST_DATA_BIT);
   assign ack_edge = (state_r != ST_IDLE) && (bit_cnt_r == BITS_PER_BYTE);
   assign addr_hit = (rx_byte[7:1] == my_addr);
   assign wr_store = byte_end && (state_r == ST_WDATA) && !first_w_r;
   assign rd_load  = ack_edge &&
                     (((state_r == ST_ADDR) && shift_r[0]) ||
                      ((state_r == ST_RDATA) && !i_sda_in));

   // START seen marker
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         start_seen_r <= 1'b0;
      end else if (start_new) begin
         start_seen_r <= start_tog_r;
      end
   end

   // Sequencer
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         state_r <= ST_IDLE;
      end else if (start_new) begin
         state_r <= ST_ADDR;
      end else if (byte_end && (state_r == ST_ADDR) && !addr_hit) begin
         // Not ours: keep off the bus until the next START
         state_r <= ST_IDLE;
      end else if (ack_edge) begin
         case (state_r)
            ST_ADDR: begin
               if (shift_r[0]) begin
                  state_r <= ST_RDATA;
               end else begin
                  state_r <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (i_sda_in) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= state_r;
         endcase
      end
   end

   // Bit counter; the START edge already took address bit seven
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         bit_cnt_r <= '0;
      end else if (start_new) begin
         bit_cnt_r <= BITCNT_W'(1);
      end else if (state_r != ST_IDLE) begin
         if (ack_edge) begin
            bit_cnt_r <= '0;
         end else begin
            bit_cnt_r <= bit_cnt_r + BITCNT_W'(1);
         end
      end
   end

   // Shifter keeps the eighth bit, so R/W sits at bit zero
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         shift_r <= '0;
      end else if (start_new) begin
         shift_r <= {6'h00, i_sda_in};
      end else if ((state_r != ST_IDLE) && !ack_edge) begin
         shift_r <= rx_byte[6:0];
      end
   end

   // Byte pointer
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         ptr_r <= '0;
      end else if (start_new) begin
         ptr_r <= '0;
      end else if (wr_store || rd_load) begin
         ptr_r <= ptr_r + PTR_W'(1);
      end
   end

   // Dummy offset flag
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         first_w_r <= 1'b1;
      end else if (start_new) begin
         first_w_r <= 1'b1;
      end else if (byte_end && (state_r == ST_WDATA)) begin
         first_w_r <= 1'b0;
      end
   end

   // Acknowledge request, served on the ninth clock
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         ack_pend_r <= 1'b0;
      end else if (start_new) begin
         ack_pend_r <= 1'b0;
      end else if (byte_end) begin
         case (state_r)
            ST_ADDR:  ack_pend_r <= addr_hit;
            ST_WDATA: ack_pend_r <= 1'b1;
            default:  ack_pend_r <= 1'b0;
         endcase
      end else if (ack_edge) begin
         ack_pend_r <= 1'b0;
      end
   end

   // Read byte, loaded on the acknowledge clock
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         tx_r <= READ_ZERO;
      end else if (!start_new && rd_load) begin
         tx_r <= read_byte(ptr_r, cfg_r);
      end
   end

   // Write capture toward the system domain
   always_ff @(posedge i_scl) begin
      if (rst_link_r) begin
         wr_byte_r <= READ_ZERO;
         wr_idx_r  <= '0;
         wr_tog_r  <= 1'b0;
      end else if (!start_new && wr_store) begin
         wr_byte_r <= rx_byte;
         wr_idx_r  <= ptr_r;
         wr_tog_r  <= ~wr_tog_r;
      end
   end

   // Open drain: the level is always low, only the enable moves
   always_ff @(negedge i_scl) begin
      o_sda_out <= 1'b0;
   end

   // Drive data on the falling SCL edge, the low phase of the bus
   always_ff @(negedge i_scl) begin
      if (rst_link_r) begin
         o_sda_oe <= 1'b0;
      end else if (bit_cnt_r == BITS_PER_BYTE) begin
         o_sda_oe <= ack_pend_r;
      end else if (state_r == ST_RDATA) begin
         o_sda_oe <= ~tx_r[3'(LAST_DATA_BIT - bit_cnt_r)];
      end else begin
         o_sda_oe <= 1'b0;
      end
   end

   // Write event into the system domain
   logic       wr_meta_r;
   logic       wr_sync_r;
   logic       wr_last_r;
   logic       wr_evt;

   always_ff @(posedge i_sys_clk) begin
      wr_meta_r <= wr_tog_r;
      wr_sync_r <= wr_meta_r;
      wr_last_r <= wr_sync_r;
   end

   // Byte and index hold for nine bus clocks, far past the sync
   assign wr_evt = wr_sync_r ^ wr_last_r;

   // Per-channel bank; reserved bytes match no index and are dropped
   logic       en_r     [NUM_CH];
   logic [3:0] boost_r  [NUM_CH];
   logic [1:0] swing_r  [NUM_CH];
   logic [1:0] deemph_r [NUM_CH];

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      localparam logic [3:0] BOOST_IDX = (c < NUM_CH / 2) ? IDX_BOOST_LO
                                                          : IDX_BOOST_HI;
      localparam int         BOOST_LSB = 4 * (c % 2);
      localparam int         PAIR_LSB  = 2 * c;

      always_ff @(posedge i_sys_clk) begin
         if (i_rst) begin
            en_r[c]     <= strap_sync_r.power_enable_strap;
            boost_r[c]  <= strap_sync_r.eq_boost_code;
            swing_r[c]  <= {strap_sync_r.output_swing_code,
                            SWING_LO_RESET};
            deemph_r[c] <= strap_sync_r.deemphasis_code;
         end else if (wr_evt) begin
            if (wr_idx_r == IDX_ENABLES) begin
               en_r[c] <= wr_byte_r[EN_LSB + c];
            end
            if (wr_idx_r == BOOST_IDX) begin
               boost_r[c] <= wr_byte_r[BOOST_LSB +: 4];
            end
            if (wr_idx_r == IDX_SWING) begin
               swing_r[c] <= wr_byte_r[PAIR_LSB +: 2];
            end
            if (wr_idx_r == IDX_DEEMPH) begin
               deemph_r[c] <= wr_byte_r[PAIR_LSB +: 2];
            end
         end
      end
   end

   always_comb begin
      cfg_r = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         cfg_r.enable[c]        = en_r[c];
         cfg_r.boost[4*c +: 4]  = boost_r[c];
         cfg_r.swing[2*c +: 2]  = swing_r[c];
         cfg_r.deemph[2*c +: 2] = deemph_r[c];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      o_settings <= cfg_r;
   end

endmodule : cfg_slave

/* File: cfg_slave_assertions.sv */
/* Port checker for cfg_slave.
 Assumes straps static while it runs. */
`timescale 1ns/1ps
module cfg_chk
   import cfg_slave_pkg::*;
(
   input wire logic      i_sys_clk,
   input wire logic      i_rst,
   input wire logic      i_scl,
   input wire logic      o_sda_out,
   input wire logic      o_sda_oe,
   input wire straps_s   i_straps,
   input wire settings_s o_settings
);
   settings_s x;
   // Strap image at reset exit
   assign x = {{4{i_straps.power_enable_strap}},
      {4{i_straps.eq_boost_code}}, {4{i_straps.output_swing_code, 1'b1}},
      {4{i_straps.deemphasis_code}}};
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   property p_out; o_sda_out == 1'b0; endproperty
   a_out: assert property (p_out) else $error("sda high");
   // Drive may only move while bus clock is low
   property p_oe; $changed(o_sda_oe) |-> !i_scl; endproperty
   a_oe: assert property (p_oe) else $error("oe moved");
   property p_hold; $rose(o_sda_oe) |=> $stable(o_sda_oe)[*5]; endproperty
   a_hold: assert property (p_hold) else $error("oe short");
   property p_idle; $fell(i_rst) |-> !o_sda_oe [*8]; endproperty
   a_idle: assert property (p_idle) else $error("oe early");
   property p_en; $fell(i_rst) |-> o_settings.enable == x.enable; endproperty
   a_en: assert property (p_en) else $error("enable");
   property p_bst; $fell(i_rst) |-> o_settings.boost == x.boost; endproperty
   a_bst: assert property (p_bst) else $error("boost");
   property p_sw; $fell(i_rst) |-> o_settings.swing == x.swing; endproperty
   a_sw: assert property (p_sw) else $error("swing");
   property p_de; $fell(i_rst) |-> o_settings.deemph == x.deemph; endproperty
   a_de: assert property (p_de) else $error("deemph");
   c_ack: cover property ($rose(o_sda_oe));
   c_set: cover property ($changed(o_settings));
   c_rel: cover property ($fell(i_rst));
endmodule : cfg_chk
bind cfg_slave cfg_chk u_chk (.i_sys_clk, .i_rst, .i_scl, .o_sda_out,
   .o_sda_oe, .i_straps, .o_settings);

/* File: ctl_model.sv */
/* Bus controller model, 125 ns bit.
 Assumes the bench resolves the pulled-up wire. */
`timescale 1ns/1ps
module ctl_model (
   output logic      o_scl,
   output logic      o_oe,
   input  wire logic i_sda
);
   // Clock stands high between frames
   initial o_scl = 1'b1;
   initial o_oe = 1'b0;
   task automatic bt(input logic b, output logic r);
      o_oe = !b;
      #31.25 o_scl = 1'b1;
      #31.25 r = i_sda;
      #31.25 o_scl = 1'b0;
      #31.25;
   endtask : bt
   // Start when st, else stop
   task automatic cond(input logic st);
      o_oe = !st;
      #31.25 o_scl = 1'b1;
      #31.25 o_oe = st;
      #31.25 o_scl = !st;
      #31.25;
   endtask : cond
   task automatic xf(input logic [7:0] d, input logic ai,
                     output logic [7:0] q, output logic ao);
      for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
      bt(ai, ao);
   endtask : xf
endmodule : ctl_model

/* File: tb_top.sv */
/* Bench: controller model drives cfg_slave.
 Assumes cfg_chk is bound to the design. */
`timescale 1ns/1ps
module tb_top;
   import cfg_slave_pkg::*;
   logic       clk, rst, scl, m_oe, oe, a;
   logic [7:0] im [0:6];
   logic [7:0] q;
   logic [6:0] ad;
   straps_s    s;
   settings_s  se;
   int         fails = 0;
   int         n_tests = 0;
   wire        sda = !(m_oe | oe);
   cfg_slave uut (.i_sys_clk(clk), .i_rst(rst), .i_scl(scl),
      .i_sda_in(sda), .o_sda_out(), .o_sda_oe(oe), .i_straps(s),
      .o_settings(se));
   ctl_model ctl (.o_scl(scl), .o_oe(m_oe), .i_sda(sda));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e) fails++;
      if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
   endtask : chk
   task automatic final_report();
      $display("checks %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   function automatic settings_s ex();
      return {im[2][7:4], im[4], im[3], im[5], im[6]};
   endfunction : ex
   task automatic rd();
      ctl.cond(1'b1);
      ctl.xf({ad, 1'b1}, 1'b1, q, a);
      for (int i = 0; i < 9; i++) begin
         ctl.xf(8'hFF, i == 8, q, a);
         chk(q, i < 7 ? im[i] : 8'h00);
      end
      ctl.cond(1'b0);
   endtask : rd
   // Offset byte goes first and must be dropped
   task automatic wr(input logic [6:0] t, input int n);
      logic [7:0] d;
      ctl.cond(1'b1);
      ctl.xf({t, 1'b0}, 1'b1, q, a);
      chk(a, t != ad);
      for (int i = -1; i < n && t == ad; i++) begin
         d = 8'($urandom);
         ctl.xf(d, 1'b1, q, a);
         if (i == 2) im[2] = {d[7:4], 4'h0};
         if (i > 2 && i < 7) im[i] = d;
      end
      ctl.cond(1'b0);
      repeat (20) @(negedge clk);
      chk(se, ex());
   endtask : wr
   initial begin
      void'($urandom(57740));
      s = straps_s'(11'($urandom));
      rst = 1'b1;
      im = '{default: 8'h00};
      im[2] = {{4{s.power_enable_strap}}, 4'h0};
      im[3] = {2{s.eq_boost_code}};
      im[4] = {2{s.eq_boost_code}};
      im[5] = {4{s.output_swing_code, 1'b1}};
      im[6] = {4{s.deemphasis_code}};
      ad = {2'b11, s.addr_strap_bit4, 2'b00, s.addr_strap_bit1,
            s.addr_strap_bit0};
      // Link reset needs bus clock edges
      repeat (4) ctl.bt(1'b1, a);
      @(negedge clk) rst = 1'b0;
      repeat (4) ctl.bt(1'b1, a);
      chk(se, ex());
      rd();
      for (int k = 0; k < 4; k++) begin
         wr(k == 2 ? ad ^ 7'h10 : ad, k == 1 ? 0 : 9 - k);
         rd();
      end
      final_report();
   end
   initial begin
      #400us;
      fails++;
      final_report();
   end
endmodule : tb_top
